//--- src/pmc_map.svh
/*
  Constants of the PHY mode, polarity, interrupt and reset control block:
  timing figures, derived cycle counts, counts and reset values.
  Assumes a 40 MHz core clock; included by its bare name.
*/
// Behaviour
// R1 - In 10 Mbps, three inverted link pulses or one inverted idle pulse flag reverse polarity.
// R2 - Detected reverse polarity is corrected automatically unless autopolarity is disabled.
// R3 - The autopolarity disable bit stops automatic polarity correction.
// R4 - At 100 Mbps no polarity detection or correction is done.
// R5 - Full duplex lets transmit and receive overlap and suppresses collision.
// R6 - Duplex comes from the forced duplex bit or from autonegotiation.
// R7 - Without autonegotiation the speed bit picks 100 or 10 Mbps.
// R8 - Loopback echoes MII transmit to receive, disables line paths, halts link pulses.
// R9 - Powerdown tristates line outputs and stops everything but the management port.
// R10 - Leaving powerdown sets isolate; software clears it to resume MII traffic.
// R11 - Ready for normal operation within 500 ms after powerdown ends.
// R12 - Unmasked status bits latch on change, raise the interrupt, hold until read.
// R13 - A read drops the interrupt and refreshes latched bits to current values.
// R14 - A set mask bit removes its status bit from the interrupt sources.
// R15 - A pending interrupt shows as a MAC-side flag and a PHY status bit.
// R16 - Reset pin high 100 ns or soft reset bit high resets the chip.
// R17 - After a pin reset, a present enabled EEPROM loads the configuration.
// R18 - The system must reset after power-up; MAC bits are otherwise undefined.
// R19 - PHY resets on power-up, pin, soft reset fall or self-clearing bit.
// R20 - Power-up or bit reset pulses, restores defaults, latches address, clears bit.
// R21 - A pin reset keeps the PHY in reset while the pin stays high.
// R22 - Software waits 50 ms after reset before touching the PHY.
// R23 - With MAC autonegotiation select clear, MAC speed and duplex bits rule.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

`define PMC_CLK_PERIOD_NS    25
`define PMC_PIN_RST_MIN_NS   100
`define PMC_PIN_RST_MIN_CYC  ((`PMC_PIN_RST_MIN_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_PDN_READY_MS     500
`define PMC_PDN_READY_CYC    ((`PMC_PDN_READY_MS * 1000000) / `PMC_CLK_PERIOD_NS)
`define PMC_RST_READY_MS     50
`define PMC_RST_READY_CYC    ((`PMC_RST_READY_MS * 1000000) / `PMC_CLK_PERIOD_NS)
`define PMC_RST_PULSE_CYC    16
`define PMC_POL_PULSES       3
`define PMC_N_EXT_SRC        4
`define PMC_ISOLATE_RST      1'b0
`define PMC_REVPOL_RST       1'b0
`define PMC_ADDR_RST         5'h00

`endif

//--- src/pmc_pkg.sv
/*
  Types of the PHY mode, polarity, interrupt and reset control block.
  Assumes nothing of its surroundings.
*/
package pmc_pkg;

  // Sequencing of the PHY-level reset.
  typedef enum logic [1:0] {
    pmc_st_run,
    pmc_st_pin,
    pmc_st_pulse
  } pmc_rst_state_t;

endpackage : pmc_pkg

//--- src/pmc_phy_ctrl.sv
/*
  Mode, receive polarity, loopback, powerdown, interrupt latching and reset
  sequencing of an integrated 10/100 PHY. Control bits arrive as plain ports.
  Assumes the reset pin is asynchronous, all other inputs are on clk.
*/
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_phy_ctrl #(
  parameter int unsigned N_EXT         = `PMC_N_EXT_SRC,
  parameter int unsigned PDN_READY_CYC = `PMC_PDN_READY_CYC,
  parameter int unsigned RST_READY_CYC = `PMC_RST_READY_CYC,
  parameter int unsigned RST_PULSE_CYC = `PMC_RST_PULSE_CYC
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Reset sources and reset status.
  input  wire logic             reset_pin,
  input  wire logic             soft_rst,
  input  wire logic             phy_rst_set,
  input  wire logic [4:0]       phy_addr_strap,
  input  wire logic             eeprom_present,
  input  wire logic             eeprom_enable,
  output logic                  chip_rst,
  output logic                  phy_rst_busy,
  output logic                  eeprom_load,
  output logic [4:0]            mgmt_addr,
  output logic                  phy_access_ok,
  output logic                  phy_ready,
  // Mode control.
  input  wire logic             phy_power_down,
  input  wire logic             phy_isolate_clr,
  input  wire logic             ctl_loopback,
  input  wire logic             ctl_mac_autonegotiation_select_en,
  input  wire logic             ctl_speed100,
  input  wire logic             ctl_duplex,
  input  wire logic             mac_autonegotiation_select,
  input  wire logic             mac_speed_force,
  input  wire logic             mac_duplex_force,
  input  wire logic             autopol_disable,
  input  wire logic             mac_autonegotiation_select_speed100,
  input  wire logic             mac_autonegotiation_select_full,
  output logic                  phy_isolate,
  output logic                  speed100,
  output logic                  full_duplex,
  // Receive polarity.
  input  wire logic             link_pulse_seen,
  input  wire logic             link_pulse_inv,
  input  wire logic             start_of_idle_pulse,
  input  wire logic             soi_inv,
  input  wire logic             tp_rx_bit,
  output logic                  reverse_polarity,
  output logic                  tp_rx_bit_corr,
  // Internal MII and twisted-pair data paths.
  input  wire logic [3:0]       mii_txd,
  input  wire logic             mii_tx_en,
  input  wire logic [3:0]       tp_rxd,
  input  wire logic             tp_crs,
  input  wire logic             tp_col,
  output logic [3:0]            mii_rxd,
  output logic                  mii_crs,
  output logic                  mii_col,
  output logic [3:0]            tp_txd,
  output logic                  tp_tx_en,
  output logic                  tp_tx_oe,
  output logic                  link_pulse_en,
  // Interrupt status.
  input  wire logic [N_EXT-1:0] int_src,
  input  wire logic [N_EXT:0]   int_mask,
  input  wire logic             stat_rd,
  output logic [N_EXT:0]        stat_latched,
  output logic                  phy_int,
  output logic                  mac_side_phy_irq_flag
);

  localparam int unsigned NSRC      = N_EXT + 1;
  localparam logic [3:0]  PIN_MIN   = 4'(`PMC_PIN_RST_MIN_CYC);
  localparam logic [7:0]  PULSE_MAX = 8'(RST_PULSE_CYC - 1);
  localparam logic [1:0]  POL_LAST  = 2'(`PMC_POL_PULSES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin filtering.

  logic [2:0] pin_sync_q, pin_sync_d;
  logic       pin_flt_q, pin_flt_d;
  logic [3:0] pin_cnt_q, pin_cnt_d;
  logic       pin_act_q, pin_act_d;
  logic       soft_q;

  // The pin passes three flops; a level counts once the last two agree.
  always_comb begin
    pin_sync_d = {pin_sync_q[1:0], reset_pin};
    pin_flt_d  = (pin_sync_q[1] == pin_sync_q[2]) ? pin_sync_q[2] : pin_flt_q;
    pin_cnt_d  = pin_flt_q ? ((pin_cnt_q < PIN_MIN) ? pin_cnt_q + 4'h1 : pin_cnt_q) : 4'h0;
    pin_act_d  = pin_flt_q && (pin_cnt_q + 4'h1 >= PIN_MIN); // [R16] [R21]
  end

  // Registers of the pin filter.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= 3'h0;
      pin_flt_q  <= 1'b0;
      pin_cnt_q  <= 4'h0;
      pin_act_q  <= 1'b0;
      soft_q     <= 1'b0;
    end else begin
      pin_sync_q <= pin_sync_d;
      pin_flt_q  <= pin_flt_d;
      pin_cnt_q  <= pin_cnt_d;
      pin_act_q  <= pin_act_d;
      soft_q     <= soft_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PHY reset sequencing and readiness.

  pmc_pkg::pmc_rst_state_t st_q, st_d;
  logic [7:0]  pulse_q, pulse_d;
  logic [31:0] rdy_q, rdy_d;
  logic [4:0]  addr_q, addr_d;
  logic        eel_q, eel_d;
  logic        chip_q, chip_d;
  logic        pdn_q;
  logic        iso_q, iso_d;
  logic        in_rst;
  logic        pulse_end;

  assign in_rst    = (st_q != pmc_pkg::pmc_st_run);
  assign pulse_end = (st_q == pmc_pkg::pmc_st_pulse) && (pulse_q == 8'h00);

  // Power-up enters the pulse state; the pin holds reset; a bit or soft
  // reset release starts a pulse. Readiness counts from reset or powerdown end.
  always_comb begin
    st_d    = st_q;
    pulse_d = pulse_q;
    addr_d  = addr_q;
    eel_d   = 1'b0;
    rdy_d   = (rdy_q != 32'h0) ? rdy_q - 32'h1 : rdy_q;
    chip_d  = pin_act_d || soft_rst; // [R16]
    case (st_q)
      pmc_pkg::pmc_st_run: begin
        if (phy_rst_set || (soft_q && !soft_rst)) begin // [R19]
          st_d    = pmc_pkg::pmc_st_pulse;
          pulse_d = PULSE_MAX;
        end
      end
      pmc_pkg::pmc_st_pin: begin
        if (!pin_act_q) begin // [R21]
          st_d    = pmc_pkg::pmc_st_pulse;
          pulse_d = PULSE_MAX;
          eel_d   = eeprom_present && eeprom_enable; // [R17]
        end
      end
      pmc_pkg::pmc_st_pulse: begin
        if (pulse_q == 8'h00) begin // [R20]
          st_d   = pmc_pkg::pmc_st_run;
          addr_d = phy_addr_strap;
          rdy_d  = RST_READY_CYC; // [R22]
        end else begin
          pulse_d = pulse_q - 8'h01;
        end
      end
      default: begin
        st_d = pmc_pkg::pmc_st_pulse;
      end
    endcase
    if (pin_act_q) begin
      st_d = pmc_pkg::pmc_st_pin; // [R19]
    end
    if (pdn_q && !phy_power_down && !in_rst) begin
      rdy_d = PDN_READY_CYC; // [R11]
    end
  end

  // Registers of the reset sequencer; power-up acts as a reset pulse.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= pmc_pkg::pmc_st_pulse; // [R18] [R20]
      pulse_q <= PULSE_MAX;
      rdy_q   <= 32'h0;
      addr_q  <= `PMC_ADDR_RST;
      eel_q   <= 1'b0;
      chip_q  <= 1'b0;
      pdn_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      pulse_q <= pulse_d;
      rdy_q   <= rdy_d;
      addr_q  <= addr_d;
      eel_q   <= eel_d;
      chip_q  <= chip_d;
      pdn_q   <= phy_power_down;
    end
  end

  assign chip_rst      = chip_q;
  assign phy_rst_busy  = in_rst; // [R19]
  assign eeprom_load   = eel_q;
  assign mgmt_addr     = addr_q;
  assign phy_access_ok = !in_rst && (rdy_q == 32'h0);
  assign phy_ready     = phy_access_ok && !phy_power_down && !iso_q; // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection, isolation and receive polarity.

  logic       spd_q, spd_d;
  logic       fdx_q, fdx_d;
  logic       rev_q, rev_d;
  logic [1:0] inv_q, inv_d;
  logic [1:0] nrm_q, nrm_d;
  logic       rxc_q, rxc_d;
  logic       pol_on;

  assign pol_on = !spd_q && !phy_power_down && !ctl_loopback && !in_rst;

  // Speed and duplex come from MAC force bits, PHY control bits or negotiation.
  always_comb begin
    if (!mac_autonegotiation_select) begin // [R23]
      spd_d = mac_speed_force;
      fdx_d = mac_duplex_force;
    end else if (!ctl_mac_autonegotiation_select_en) begin // [R6] [R7]
      spd_d = ctl_speed100;
      fdx_d = ctl_duplex;
    end else begin
      spd_d = mac_autonegotiation_select_speed100; // [R7]
      fdx_d = mac_autonegotiation_select_full; // [R6]
    end
    // Leaving powerdown isolates the MII; setting beats a same-cycle clear.
    if (in_rst) begin
      iso_d = `PMC_ISOLATE_RST;
    end else if (pdn_q && !phy_power_down) begin
      iso_d = 1'b1; // [R10]
    end else if (phy_isolate_clr) begin
      iso_d = 1'b0;
    end else begin
      iso_d = iso_q;
    end
    // Polarity tracking on link pulses and end-of-frame idle pulses.
    rev_d = rev_q;
    inv_d = inv_q;
    nrm_d = nrm_q;
    if (in_rst || spd_q) begin
      rev_d = 1'b0; // [R4]
      inv_d = 2'h0;
      nrm_d = 2'h0;
    end else if (pol_on && start_of_idle_pulse) begin
      rev_d = soi_inv; // [R1]
      inv_d = 2'h0;
      nrm_d = 2'h0;
    end else if (pol_on && link_pulse_seen) begin
      if (link_pulse_inv) begin
        nrm_d = 2'h0;
        inv_d = (inv_q == POL_LAST) ? 2'h0 : inv_q + 2'h1;
        rev_d = (inv_q == POL_LAST) ? 1'b1 : rev_q; // [R1]
      end else begin
        inv_d = 2'h0;
        nrm_d = (nrm_q == POL_LAST) ? 2'h0 : nrm_q + 2'h1;
        rev_d = (nrm_q == POL_LAST) ? 1'b0 : rev_q;
      end
    end
    rxc_d = tp_rx_bit ^ (rev_q && !autopol_disable); // [R2] [R3]
  end

  // Registers of mode and polarity.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iso_q <= `PMC_ISOLATE_RST;
      spd_q <= 1'b0;
      fdx_q <= 1'b0;
      rev_q <= `PMC_REVPOL_RST;
      inv_q <= 2'h0;
      nrm_q <= 2'h0;
      rxc_q <= 1'b0;
    end else begin
      iso_q <= iso_d;
      spd_q <= spd_d;
      fdx_q <= fdx_d;
      rev_q <= rev_d;
      inv_q <= inv_d;
      nrm_q <= nrm_d;
      rxc_q <= rxc_d;
    end
  end

  assign phy_isolate      = iso_q;
  assign speed100         = spd_q;
  assign full_duplex      = fdx_q;
  assign reverse_polarity = rev_q;
  assign tp_rx_bit_corr   = rxc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Data paths between the internal MII and the line.

  logic [3:0] rxd_q, rxd_d, txd_q, txd_d;
  logic       crs_q, crs_d, col_q, col_d, txe_q, txe_d, oe_q, oe_d, lp_q, lp_d;
  logic       dead;

  assign dead = in_rst || phy_power_down; // [R9]

  // Loopback echoes transmit onto receive; full duplex hides collisions.
  always_comb begin
    oe_d = !dead; // [R9]
    lp_d = !dead && !spd_q && !ctl_loopback; // [R8]
    if (dead || iso_q) begin
      rxd_d = 4'h0;
      crs_d = 1'b0;
      col_d = 1'b0;
      txd_d = 4'h0;
      txe_d = 1'b0;
    end else if (ctl_loopback) begin
      rxd_d = mii_txd; // [R8]
      crs_d = mii_tx_en;
      col_d = 1'b0;
      txd_d = 4'h0;
      txe_d = 1'b0;
    end else begin
      rxd_d = tp_rxd;
      crs_d = tp_crs;
      col_d = tp_col && !fdx_q; // [R5]
      txd_d = mii_txd;
      txe_d = mii_tx_en;
    end
  end

  // Registers of the data paths.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_q <= 4'h0;
      txd_q <= 4'h0;
      crs_q <= 1'b0;
      col_q <= 1'b0;
      txe_q <= 1'b0;
      oe_q  <= 1'b0;
      lp_q  <= 1'b0;
    end else begin
      rxd_q <= rxd_d;
      txd_q <= txd_d;
      crs_q <= crs_d;
      col_q <= col_d;
      txe_q <= txe_d;
      oe_q  <= oe_d;
      lp_q  <= lp_d;
    end
  end

  assign mii_rxd       = rxd_q;
  assign mii_crs       = crs_q;
  assign mii_col       = col_q;
  assign tp_txd        = txd_q;
  assign tp_tx_en      = txe_q;
  assign tp_tx_oe      = oe_q;
  assign link_pulse_en = lp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Latching interrupt status bits.

  logic [NSRC-1:0] src, shown_q, shown_d, pend_q, pend_d;
  logic            int_q;

  assign src = {int_src, rev_q};

  // Each bit latches on change unless masked, and a read refreshes it.
  for (genvar i = 0; i < NSRC; i++) begin : g_stat
    always_comb begin
      shown_d[i] = shown_q[i];
      pend_d[i]  = pend_q[i];
      if (in_rst) begin
        shown_d[i] = src[i];
        pend_d[i]  = 1'b0;
      end else if (stat_rd || int_mask[i]) begin
        shown_d[i] = src[i]; // [R13] [R14]
        pend_d[i]  = 1'b0;
      end else if (!pend_q[i] && (src[i] != shown_q[i])) begin
        shown_d[i] = src[i]; // [R12]
        pend_d[i]  = 1'b1;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        shown_q[i] <= 1'b0;
        pend_q[i]  <= 1'b0;
      end else begin
        shown_q[i] <= shown_d[i];
        pend_q[i]  <= pend_d[i];
      end
    end
  end

  // One pending flag feeds both indications.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_q <= 1'b0;
    end else begin
      int_q <= |pend_d; // [R12] [R15]
    end
  end

  assign stat_latched          = shown_q;
  assign phy_int               = int_q; // [R15]
  assign mac_side_phy_irq_flag = int_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_third_inv;
    pol_on && !start_of_idle_pulse && link_pulse_seen && link_pulse_inv && inv_q == 2'h2;
  endsequence
  sequence s_pdn_exit;
    !in_rst && pdn_q && !phy_power_down;
  endsequence

  pol_third_pulse_a: assert property (s_third_inv |=> rev_q) // [R1]
    else $error("third inverted link pulse did not flag reverse polarity");
  pol_fix_on_a: assert property (rev_q && !autopol_disable |=> rxc_q != $past(tp_rx_bit)) // [R2]
    else $error("reverse polarity was not corrected");
  pol_fix_off_a: assert property (autopol_disable |=> rxc_q == $past(tp_rx_bit)) // [R3]
    else $error("polarity corrected while autopolarity disabled");
  fast_no_pol_a: assert property (spd_q |=> !rev_q) // [R4]
    else $error("reverse polarity flagged at 100 Mbps");
  fdx_no_col_a: assert property (fdx_q ##1 fdx_q |-> !col_q) // [R5]
    else $error("collision shown in full duplex");
  mac_force_a: assert property (!mac_autonegotiation_select |=>
      spd_q == $past(mac_speed_force) && fdx_q == $past(mac_duplex_force)) // [R23]
    else $error("MAC force bits ignored");
  ctl_force_a: assert property (mac_autonegotiation_select && !ctl_mac_autonegotiation_select_en |=>
      spd_q == $past(ctl_speed100) && fdx_q == $past(ctl_duplex)) // [R6]
    else $error("control speed or duplex ignored");
  loop_echo_a: assert property (ctl_loopback && !dead && !iso_q |=>
      crs_q == $past(mii_tx_en) && !lp_q && !txe_q) // [R8]
    else $error("loopback path wrong");
  pdn_hiz_a: assert property (phy_power_down |=> !oe_q && !lp_q) // [R9]
    else $error("line driven during powerdown");
  pdn_iso_a: assert property (s_pdn_exit |=> iso_q ##1 (iso_q || $past(phy_isolate_clr))) // [R10]
    else $error("isolate not set after powerdown");
  int_read_a: assert property (stat_rd |=> !int_q && !mac_side_phy_irq_flag) // [R13]
    else $error("interrupt stayed after read");
  int_mask_a: assert property (&int_mask |=> !int_q) // [R14]
    else $error("masked change raised interrupt");
  rst_bit_a: assert property (!in_rst && phy_rst_set |=> phy_rst_busy [*8]) // [R19]
    else $error("reset bit cleared too early");
  pin_hold_a: assert property (pin_act_q |-> chip_q ##1 phy_rst_busy) // [R21]
    else $error("pin reset not held");

endmodule : pmc_phy_ctrl

//--- tb/pmc_link_model.sv
/*
  Behavioural link partner: pulse events and receive line state for the PHY control block.
  Assumes callers start just after a rising clock edge.
*/
`timescale 1ns/1ps

module pmc_link_model (
  // Clock.
  input  wire logic       clk,
  // Pulse events seen on the line.
  output logic            link_pulse_seen,
  output logic            link_pulse_inv,
  output logic            start_of_idle_pulse,
  output logic            soi_inv,
  // Receive data and line state.
  output logic            tp_rx_bit,
  output logic [3:0]      tp_rxd,
  output logic            tp_crs,
  output logic            tp_col
);
  // The line starts quiet with no events pending.
  initial begin
    {link_pulse_seen, link_pulse_inv, start_of_idle_pulse, soi_inv} = 4'h0;
    {tp_rx_bit, tp_rxd, tp_crs, tp_col} = 7'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sends one link or idle pulse of one cycle; the polarity line then flips so a stale
  // value is never mistaken for a real one.
  task automatic send(input logic inv, input logic idle);
    @(posedge clk);
    #2;
    link_pulse_seen     = ~idle;
    start_of_idle_pulse = idle;
    link_pulse_inv      = inv;
    soi_inv             = inv;
    @(posedge clk);
    #2;
    link_pulse_seen     = 1'b0;
    start_of_idle_pulse = 1'b0;
    link_pulse_inv      = ~inv;
    soi_inv             = ~inv;
  endtask : send

  // Sets the receive data, carrier, collision and raw receive bit.
  task automatic line(input logic [3:0] d, input logic crs, input logic col, input logic b);
    tp_rxd    = d;
    tp_crs    = crs;
    tp_col    = col;
    tp_rx_bit = b;
  endtask : line
endmodule : pmc_link_model

//--- tb/test_phy_mode_control_and_reset.sv
/*
  Self-checking bench of the PHY mode, polarity, interrupt and reset block.
  Assumes short readiness counts (50 and 20 cycles) and a 40 MHz clock.
*/
`timescale 1ns/1ps

module test_phy_mode_control_and_reset;
  logic clk, rst_n, reset_pin, soft_rst, phy_rst_set, eeprom_present, eeprom_enable;
  logic phy_power_down, phy_isolate_clr, ctl_loopback, ctl_mac_autonegotiation_select_en, ctl_speed100, ctl_duplex;
  logic mac_autonegotiation_select, mac_speed_force, mac_duplex_force, autopol_disable;
  logic mac_autonegotiation_select_speed100, mac_autonegotiation_select_full, mii_tx_en, stat_rd, esp, ed, seen;
  logic [4:0] phy_addr_strap, int_mask;
  logic [3:0] mii_txd, int_src;
  wire  chip_rst, phy_rst_busy, eeprom_load, phy_access_ok, phy_ready, phy_isolate, speed100;
  wire  full_duplex, reverse_polarity, tp_rx_bit_corr, mii_crs, mii_col, tp_tx_en, tp_tx_oe;
  wire  link_pulse_en, phy_int, mac_side_phy_irq_flag, link_pulse_seen, link_pulse_inv;
  wire  start_of_idle_pulse, soi_inv, tp_rx_bit, tp_crs, tp_col;
  wire  [4:0] mgmt_addr, stat_latched;
  wire  [3:0] mii_rxd, tp_txd, tp_rxd;
  int   bad_count, total_checks;

  // Design with shortened readiness counts.
  pmc_phy_ctrl #(.PDN_READY_CYC(50), .RST_READY_CYC(20)) DUT (
    .clk, .rst_n, .reset_pin, .soft_rst, .phy_rst_set, .phy_addr_strap, .eeprom_present,
    .eeprom_enable, .chip_rst, .phy_rst_busy, .eeprom_load, .mgmt_addr, .phy_access_ok,
    .phy_ready, .phy_power_down, .phy_isolate_clr, .ctl_loopback, .ctl_mac_autonegotiation_select_en,
    .ctl_speed100, .ctl_duplex, .mac_autonegotiation_select, .mac_speed_force,
    .mac_duplex_force, .autopol_disable, .mac_autonegotiation_select_speed100, .mac_autonegotiation_select_full, .phy_isolate,
    .speed100, .full_duplex, .link_pulse_seen, .link_pulse_inv, .start_of_idle_pulse,
    .soi_inv, .tp_rx_bit, .reverse_polarity, .tp_rx_bit_corr, .mii_txd, .mii_tx_en,
    .tp_rxd, .tp_crs, .tp_col, .mii_rxd, .mii_crs, .mii_col, .tp_txd, .tp_tx_en,
    .tp_tx_oe, .link_pulse_en, .int_src, .int_mask, .stat_rd, .stat_latched, .phy_int,
    .mac_side_phy_irq_flag);

  // Far side of the line.
  pmc_link_model m (
    .clk, .link_pulse_seen, .link_pulse_inv, .start_of_idle_pulse, .soi_inv, .tp_rx_bit,
    .tp_rxd, .tp_crs, .tp_col);

  // Clock of 25 ns period.
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the result.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Moves n edges on, then a little past the edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  // Forces speed and duplex through the MAC-side bits.
  task automatic mode(input logic sp, input logic fd);
    mac_autonegotiation_select = 1'b0;
    mac_speed_force            = sp;
    mac_duplex_force           = fd;
    step(2);
  endtask : mode

  // Waits, bounded, for the reset pulse to end and access to be allowed.
  task automatic wait_ready();
    int k;
    k = 0;
    while (phy_rst_busy !== 1'b0 && k < 60) begin
      step(1);
      k++;
    end
    while (phy_access_ok !== 1'b1 && k < 100) begin
      step(1);
      k++;
    end
    chk(phy_access_ok, 1'b1);
  endtask : wait_ready

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short.
  initial begin
    #(25 * 4000);
    bad_count++;
    test_done();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {reset_pin, soft_rst, phy_rst_set, eeprom_present, eeprom_enable, phy_power_down} = 6'h00;
    {phy_isolate_clr, ctl_loopback, ctl_mac_autonegotiation_select_en, ctl_speed100, ctl_duplex} = 5'h00;
    {mac_autonegotiation_select, mac_speed_force, mac_duplex_force, autopol_disable} = 4'h0;
    {mac_autonegotiation_select_speed100, mac_autonegotiation_select_full, mii_tx_en, stat_rd} = 4'h0;
    phy_addr_strap = 5'h05;
    int_mask = 5'h01;
    mii_txd = 4'h0;
    int_src = 4'h0;
    bad_count = 0;
    total_checks = 0;
    step(2);
    rst_n = 1'b1;
    wait_ready();
    chk(mgmt_addr, 5'h05);
    // Speed and duplex sources for every select combination.
    for (int i = 0; i < 16; i++) begin
      mac_autonegotiation_select = i[0];
      ctl_mac_autonegotiation_select_en = i[1];
      {mac_speed_force, mac_autonegotiation_select_full} = {2{i[2]}};
      mac_duplex_force = ~i[2];
      {ctl_duplex, mac_autonegotiation_select_speed100} = {2{i[3]}};
      ctl_speed100 = ~i[3];
      step(2);
      esp = !i[0] ? i[2] : (i[1] ? i[3] : ~i[3]);
      ed = !i[0] ? ~i[2] : (i[1] ? i[2] : i[3]);
      chk(speed100, esp);
      chk(full_duplex, ed);
    end
    $display("test mode select done");
    // Receive polarity at 10 and 100 Mbps.
    mode(1'b0, 1'b0);
    m.send(1'b1, 1'b0);
    m.send(1'b1, 1'b0);
    step(2);
    chk(reverse_polarity, 1'b0);
    m.send(1'b1, 1'b0);
    step(2);
    chk(reverse_polarity, 1'b1);
    m.line(4'h5, 1'b1, 1'b1, 1'b1);
    step(2);
    chk(tp_rx_bit_corr, 1'b0);
    autopol_disable = 1'b1;
    step(2);
    chk(tp_rx_bit_corr, 1'b1);
    autopol_disable = 1'b0;
    m.send(1'b0, 1'b1);
    step(2);
    chk(reverse_polarity, 1'b0);
    m.send(1'b1, 1'b1);
    step(2);
    chk(reverse_polarity, 1'b1);
    mode(1'b1, 1'b0);
    m.send(1'b1, 1'b1);
    step(2);
    chk(reverse_polarity, 1'b0);
    chk(tp_rx_bit_corr, 1'b1);
    $display("test polarity done");
    // Collision by duplex, then loopback.
    mode(1'b0, 1'b1);
    chk(mii_col, 1'b0);
    chk(mii_rxd, 4'h5);
    mode(1'b0, 1'b0);
    chk(mii_col, 1'b1);
    mii_txd = 4'ha;
    mii_tx_en = 1'b1;
    ctl_loopback = 1'b1;
    step(2);
    chk({mii_rxd, mii_crs, tp_tx_en, link_pulse_en}, {4'ha, 3'b100});
    chk({mii_col, full_duplex}, 2'b00);
    ctl_loopback = 1'b0;
    step(2);
    chk({tp_txd, tp_tx_en, link_pulse_en}, {4'ha, 2'b11});
    $display("test data paths done");
    // Powerdown, isolation and readiness.
    phy_power_down = 1'b1;
    step(2);
    chk({tp_tx_oe, mii_rxd, link_pulse_en}, 6'h00);
    phy_power_down = 1'b0;
    step(2);
    chk({phy_isolate, phy_ready}, 2'b10);
    phy_isolate_clr = 1'b1;
    step(1);
    phy_isolate_clr = 1'b0;
    step(2);
    chk(phy_isolate, 1'b0);
    step(50);
    chk(phy_ready, 1'b1);
    $display("test powerdown done");
    // Latched interrupt bits, read and mask.
    int_src = 4'h1;
    step(2);
    chk(stat_latched[4:1], 4'h1);
    chk({phy_int, mac_side_phy_irq_flag}, 2'b11);
    int_src = 4'h0;
    step(2);
    chk(stat_latched[4:1], 4'h1);
    stat_rd = 1'b1;
    step(1);
    stat_rd = 1'b0;
    step(1);
    chk({phy_int, mac_side_phy_irq_flag, stat_latched[4:1]}, 6'h00);
    int_mask = 5'h03;
    int_src = 4'h1;
    step(2);
    chk(phy_int, 1'b0);
    int_mask = 5'h1f;
    int_src = 4'he;
    step(2);
    chk({phy_int, mac_side_phy_irq_flag}, 2'b00);
    $display("test interrupt done");
    // Reset bit, soft reset and reset pin.
    phy_addr_strap = 5'h1b;
    phy_rst_set = 1'b1;
    step(1);
    phy_rst_set = 1'b0;
    chk(phy_rst_busy, 1'b1);
    wait_ready();
    chk(mgmt_addr, 5'h1b);
    soft_rst = 1'b1;
    step(2);
    chk(chip_rst, 1'b1);
    soft_rst = 1'b0;
    step(2);
    chk(phy_rst_busy, 1'b1);
    wait_ready();
    {eeprom_present, eeprom_enable, reset_pin} = 3'b111;
    step(10);
    chk({chip_rst, phy_rst_busy}, 2'b11);
    step(4);
    chk(phy_rst_busy, 1'b1);
    reset_pin = 1'b0;
    seen = 1'b0;
    repeat (12) begin
      step(1);
      if (eeprom_load === 1'b1)
        seen = 1'b1;
    end
    chk(seen, 1'b1);
    wait_ready();
    chk(chip_rst, 1'b0);
    $display("test resets done");
    test_done();
  end
endmodule : test_phy_mode_control_and_reset
